// *** src/csbu_pkg.sv ***
`default_nettype none
package csbu_pkg;
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 16'h0001;
    localparam logic [PC_W-1:0] PC_TWO = 16'h0002;
    localparam logic [PC_W-1:0] PC_THREE = 16'h0003;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    typedef enum logic [3:0]
    {
        CSBU_OP_NONE,
        CSBU_OP_COMPARE_IMM,
        CSBU_OP_SKIP_REG_BIT_CLEAR,
        CSBU_OP_SKIP_REG_BIT_SET,
        CSBU_OP_SKIP_IO_BIT_CLEAR,
        CSBU_OP_SKIP_IO_BIT_SET,
        CSBU_OP_BRANCH_FLAG_SET,
        CSBU_OP_BRANCH_FLAG_CLEAR,
        CSBU_OP_BRANCH_CARRY_SET,
        CSBU_OP_BRANCH_CARRY_CLEAR,
        CSBU_OP_BRANCH_SAME_OR_HIGHER,
        CSBU_OP_BRANCH_LOWER
    } csbu_op_t;
endpackage : csbu_pkg
`default_nettype wire

// *** src/csbu_flags.sv ***
`default_nettype none
module csbu_flags
(
    input  wire logic       sys_clk,  // Core clock
    input  wire logic       nrst,     // Async reset, active low
    input  wire logic       wr_en,    // Load new flags
    input  wire logic [7:0] wr_data,  // New flags
    output logic      [7:0] rd_data   // Registered flags
);
    import csbu_pkg::*;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rd_data <= FLAGS_RST;
        else if (wr_en)
            rd_data <= wr_data;
    end
endmodule : csbu_flags
`default_nettype wire

// *** src/csbu_unit.sv ***
`default_nettype none
// Behaviour
// - Compare immediate subtracts constant, stores nothing, sets Z N V C S H, one cycle.
// - Register bit skip advances PC by 2 or 3 on match, flags kept.
// - I/O bit skip advances PC by 2 or 3 on match, flags kept.
// - Flag branch loads PC plus offset plus one when chosen bit matches.
// - Carry branches jump relatively when carry is one or zero.
// - Same-or-higher branches on carry zero, lower on carry one.
module csbu_unit
(
    input  wire logic                    sys_clk,      // Core clock
    input  wire logic                    nrst,         // Async reset, active low
    input  wire logic                    instr_valid,  // Instruction offered
    input  wire csbu_pkg::csbu_op_t      instr_op,     // Decoded operation
    input  wire logic [7:0]              reg_value,    // Working register operand
    input  wire logic [7:0]              imm_value,    // Immediate constant
    input  wire logic [7:0]              io_value,     // I/O register operand
    input  wire logic [2:0]              bit_sel,      // Tested bit or status bit
    input  wire logic [csbu_pkg::OFS_W-1:0] branch_ofs, // Signed word offset
    input  wire logic                    next_two_word, // Following instruction is two words
    output logic                         instr_ready,  // Accepting an instruction
    output logic [csbu_pkg::PC_W-1:0]    pc_out,       // Program counter
    output logic [7:0]                   flags_out,    // Status flags register
    output logic                         done_pulse,   // Instruction retired
    output logic [1:0]                   cycles_out    // Cycles of last instruction
);
    import csbu_pkg::*;

    // ****************************************
    // Decode
    // ****************************************
    logic [1:0]      busy_cnt_r;
    logic [1:0]      busy_cnt_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [1:0]      cyc_r;
    logic [1:0]      cyc_nxt;
    logic            done_r;
    logic [7:0]      flags;
    logic [7:0]      cmp_flags;
    logic [8:0]      diff;
    logic            take;
    logic            is_skip;
    logic            is_branch;
    logic            is_cmp;
    logic            accept;
    logic [PC_W-1:0] ofs_ext;
    logic [PC_W-1:0] skip_step;

    function automatic logic bit_of(input logic [7:0] v, input logic [2:0] b);
        bit_of = v[b];
    endfunction : bit_of

    assign accept = instr_valid && (busy_cnt_r == 2'h0);
    assign is_cmp = (instr_op == CSBU_OP_COMPARE_IMM);
    assign is_skip = (instr_op == CSBU_OP_SKIP_REG_BIT_CLEAR) || (instr_op == CSBU_OP_SKIP_REG_BIT_SET)
                  || (instr_op == CSBU_OP_SKIP_IO_BIT_CLEAR) || (instr_op == CSBU_OP_SKIP_IO_BIT_SET);
    assign is_branch = !is_cmp && !is_skip && (instr_op != CSBU_OP_NONE);

    always_comb
    begin
        take = 1'b0;
        case (instr_op)
            CSBU_OP_SKIP_REG_BIT_CLEAR:    take = !bit_of(reg_value, bit_sel);
            CSBU_OP_SKIP_REG_BIT_SET:      take = bit_of(reg_value, bit_sel);
            CSBU_OP_SKIP_IO_BIT_CLEAR:     take = !bit_of(io_value, bit_sel);
            CSBU_OP_SKIP_IO_BIT_SET:       take = bit_of(io_value, bit_sel);
            CSBU_OP_BRANCH_FLAG_SET:       take = bit_of(flags, bit_sel);
            CSBU_OP_BRANCH_FLAG_CLEAR:     take = !bit_of(flags, bit_sel);
            CSBU_OP_BRANCH_CARRY_SET:      take = flags[FLAG_C];
            CSBU_OP_BRANCH_CARRY_CLEAR:    take = !flags[FLAG_C];
            CSBU_OP_BRANCH_SAME_OR_HIGHER: take = !flags[FLAG_C];
            CSBU_OP_BRANCH_LOWER:          take = flags[FLAG_C];
            default:                       take = 1'b0;
        endcase
    end

    // ****************************************
    // Compare flags
    // ****************************************
    // subtract, keep only flags
    assign diff = {1'b0, reg_value} - {1'b0, imm_value};
    always_comb
    begin
        cmp_flags = flags;
        cmp_flags[FLAG_C] = diff[8];
        cmp_flags[FLAG_Z] = (diff[7:0] == 8'h00);
        cmp_flags[FLAG_N] = diff[7];
        cmp_flags[FLAG_V] = (reg_value[7] & ~imm_value[7] & ~diff[7]) | (~reg_value[7] & imm_value[7] & diff[7]);
        cmp_flags[FLAG_S] = diff[7] ^ cmp_flags[FLAG_V];
        cmp_flags[FLAG_H] = (~reg_value[3] & imm_value[3]) | (imm_value[3] & diff[3]) | (diff[3] & ~reg_value[3]);
    end

    // ****************************************
    // Program counter and timing
    // ****************************************
    assign ofs_ext = {{(PC_W-OFS_W){branch_ofs[OFS_W-1]}}, branch_ofs};
    // skip width follows next word count
    assign skip_step = next_two_word ? PC_THREE : PC_TWO;

    always_comb
    begin
        pc_nxt = pc_r;
        cyc_nxt = cyc_r;
        busy_cnt_nxt = (busy_cnt_r == 2'h0) ? 2'h0 : busy_cnt_r - 2'h1;
        if (accept)
        begin
            cyc_nxt = CYC_ONE;
            pc_nxt = pc_r + PC_ONE;
            if (is_skip && take)
            begin
                pc_nxt = pc_r + skip_step;
                cyc_nxt = next_two_word ? CYC_THREE : CYC_TWO;
            end
            else if (is_branch && take)
            begin
                pc_nxt = pc_r + ofs_ext + PC_ONE;
                cyc_nxt = CYC_TWO;
            end
            busy_cnt_nxt = cyc_nxt - CYC_ONE;
        end
    end

    // Flags change only on compare; skips and branches leave them alone
    csbu_flags u_flags
    (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (accept && is_cmp),
        .wr_data (cmp_flags),
        .rd_data (flags)
    );

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pc_r <= PC_RST;
            cyc_r <= CYC_ONE;
            busy_cnt_r <= 2'h0;
            done_r <= 1'b0;
            instr_ready <= 1'b1;
        end
        else
        begin
            pc_r <= pc_nxt;
            cyc_r <= cyc_nxt;
            busy_cnt_r <= busy_cnt_nxt;
            done_r <= accept;
            instr_ready <= (busy_cnt_nxt == 2'h0);
        end
    end

    assign pc_out = pc_r;
    assign flags_out = flags;
    assign done_pulse = done_r;
    assign cycles_out = cyc_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_cmp_flags;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && is_cmp) |=> (flags_out == $past(cmp_flags)) && (cycles_out == CYC_ONE) && instr_ready;
    endproperty
    a_cmp_flags: assert property (p_cmp_flags) else $error("compare flags wrong");

    property p_skip_reg;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && (instr_op == CSBU_OP_SKIP_REG_BIT_SET) && reg_value[bit_sel] && !next_two_word)
        |=> (pc_out == $past(pc_r) + PC_TWO) && $stable(flags_out) && !instr_ready ##1 instr_ready;
    endproperty
    a_skip_reg: assert property (p_skip_reg) else $error("register skip wrong");

    property p_skip_io;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && (instr_op == CSBU_OP_SKIP_IO_BIT_CLEAR) && !io_value[bit_sel])
        |=> (pc_out == $past(pc_r) + $past(skip_step)) && $stable(flags_out);
    endproperty
    a_skip_io: assert property (p_skip_io) else $error("io skip wrong");

    property p_flag_branch;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && (instr_op == CSBU_OP_BRANCH_FLAG_SET) && flags[bit_sel])
        |=> (pc_out == $past(pc_r) + $past(ofs_ext) + PC_ONE) && (cycles_out == CYC_TWO);
    endproperty
    a_flag_branch: assert property (p_flag_branch) else $error("flag branch wrong");

    property p_carry_branch;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && (instr_op == CSBU_OP_BRANCH_CARRY_CLEAR) && flags[FLAG_C])
        |=> (pc_out == $past(pc_r) + PC_ONE) && (cycles_out == CYC_ONE) && $stable(flags_out);
    endproperty
    a_carry_branch: assert property (p_carry_branch) else $error("carry branch wrong");

    property p_lower;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && (instr_op == CSBU_OP_BRANCH_LOWER) && flags[FLAG_C])
        |=> (pc_out == $past(pc_r) + $past(ofs_ext) + PC_ONE);
    endproperty
    a_lower: assert property (p_lower) else $error("lower branch wrong");

    property p_skip_long;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && is_skip && take && next_two_word)
        |=> (cycles_out == CYC_THREE) && !instr_ready [*2] ##1 instr_ready;
    endproperty
    a_skip_long: assert property (p_skip_long) else $error("two word skip wrong");

    property p_busy_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !instr_ready |=> $stable(pc_out) && $stable(flags_out);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("state moved while busy");

    c_cmp: cover property (@(posedge sys_clk) disable iff (!nrst) accept && is_cmp);
    c_skip3: cover property (@(posedge sys_clk) disable iff (!nrst) accept && is_skip && take && next_two_word);
    c_branch: cover property (@(posedge sys_clk) disable iff (!nrst) accept && is_branch && take);
endmodule : csbu_unit
`default_nettype wire

// *** test/csbu_unit_tb_top.sv ***
`default_nettype none
module csbu_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csbu_pkg::*;

    logic              sys_clk;
    logic              nrst;
    logic              instr_valid;
    csbu_op_t          instr_op;
    logic [7:0]        reg_value;
    logic [7:0]        imm_value;
    logic [7:0]        io_value;
    logic [2:0]        bit_sel;
    logic [OFS_W-1:0]  branch_ofs;
    logic              next_two_word;
    logic              instr_ready;
    logic [PC_W-1:0]   pc_out;
    logic [7:0]        flags_out;
    logic              done_pulse;
    logic [1:0]        cycles_out;
    int                miscompares = 0;
    int                checked = 0;
    int                seed = 32'h896E;
    int                busy = 0;
    logic              took = 1'b0;
    logic              rdy;
    logic [PC_W-1:0]   e_pc = PC_RST;
    logic [7:0]        e_fl = FLAGS_RST;
    logic [1:0]        e_cyc = CYC_ONE;

    csbu_unit csbu_unit_i
    (
        .sys_clk(sys_clk), .nrst(nrst), .instr_valid(instr_valid), .instr_op(instr_op),
        .reg_value(reg_value), .imm_value(imm_value), .io_value(io_value), .bit_sel(bit_sel),
        .branch_ofs(branch_ofs), .next_two_word(next_two_word), .instr_ready(instr_ready),
        .pc_out(pc_out), .flags_out(flags_out), .done_pulse(done_pulse), .cycles_out(cycles_out)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ************
    // Helpers
    // ************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
        chk(got, exp);
    endtask : chk_pc

    task automatic chk_flags(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask : chk_flags

    task automatic chk_cyc(input logic [1:0] got, input logic [1:0] exp);
        chk({14'h0000, got}, {14'h0000, exp});
    endtask : chk_cyc

    task automatic chk_bit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk_bit

    task automatic give_verdict;
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // Fresh operands every cycle, so offers made while busy are dropped
    task automatic drive;
        instr_valid   <= ($random(seed) % 8) != 0;
        instr_op      <= csbu_op_t'(4'($unsigned($random(seed)) % 12));
        {reg_value, imm_value, io_value} <= 24'($random(seed));
        bit_sel       <= 3'($random(seed));
        branch_ofs    <= 7'($random(seed));
        next_two_word <= 1'($random(seed));
    endtask : drive

    task automatic model;
        logic [8:0] r;
        logic       v;
        logic       h;
        logic       hit;
        r = {1'b0, reg_value} - {1'b0, imm_value};
        v = (reg_value[7] & ~imm_value[7] & ~r[7]) | (~reg_value[7] & imm_value[7] & r[7]);
        h = (~reg_value[3] & imm_value[3]) | (imm_value[3] & r[3]) | (r[3] & ~reg_value[3]);
        hit = 1'b0;
        e_cyc = CYC_ONE;
        case (instr_op)
            CSBU_OP_COMPARE_IMM: e_fl = {2'b00, h, r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]};
            CSBU_OP_SKIP_REG_BIT_CLEAR: hit = ~reg_value[bit_sel];
            CSBU_OP_SKIP_REG_BIT_SET: hit = reg_value[bit_sel];
            CSBU_OP_SKIP_IO_BIT_CLEAR: hit = ~io_value[bit_sel];
            CSBU_OP_SKIP_IO_BIT_SET: hit = io_value[bit_sel];
            CSBU_OP_BRANCH_FLAG_SET: hit = e_fl[bit_sel];
            CSBU_OP_BRANCH_FLAG_CLEAR: hit = ~e_fl[bit_sel];
            CSBU_OP_BRANCH_CARRY_SET, CSBU_OP_BRANCH_LOWER: hit = e_fl[FLAG_C];
            CSBU_OP_BRANCH_CARRY_CLEAR, CSBU_OP_BRANCH_SAME_OR_HIGHER: hit = ~e_fl[FLAG_C];
            default: hit = 1'b0;
        endcase
        if (!hit)
            e_pc = e_pc + PC_ONE;
        else if (instr_op inside {[CSBU_OP_SKIP_REG_BIT_CLEAR:CSBU_OP_SKIP_IO_BIT_SET]})
        begin
            e_cyc = next_two_word ? CYC_THREE : CYC_TWO;
            e_pc = e_pc + 16'(e_cyc);
        end
        else
        begin
            e_cyc = CYC_TWO;
            e_pc = e_pc + {{(PC_W - OFS_W){branch_ofs[OFS_W-1]}}, branch_ofs} + PC_ONE;
        end
        busy = int'(e_cyc) - 1;
    endtask : model

    // ************
    // Sequence
    // ************
    initial
    begin
        nrst = 1'b0;
        instr_valid = 1'b0;
        instr_op = CSBU_OP_NONE;
        {reg_value, imm_value, io_value} = 24'h000000;
        bit_sel = 3'h0;
        branch_ofs = 7'h00;
        next_two_word = 1'b0;
        // The second pass starts from a reset taken in mid-run, with work possibly in flight
        repeat (2)
        begin
            repeat (7) @(posedge sys_clk);
            @(negedge sys_clk);
            chk_pc(pc_out, PC_RST);
            chk_flags(flags_out, FLAGS_RST);
            chk_cyc(cycles_out, CYC_ONE);
            chk_bit(instr_ready, 1'b1);
            chk_bit(done_pulse, 1'b0);
            @(posedge sys_clk);
            nrst <= 1'b1;
            // Offers keep coming while busy; only a granted one may move the model
            repeat (1500)
            begin
                @(posedge sys_clk);
                drive();
                @(negedge sys_clk);
                rdy = busy == 0;
                chk_bit(instr_ready, rdy);
                chk_bit(done_pulse, took);
                if (took)
                begin
                    chk_pc(pc_out, e_pc);
                    chk_flags(flags_out, e_fl);
                    chk_cyc(cycles_out, e_cyc);
                end
                took = instr_valid && rdy;
                if (busy > 0)
                    busy--;
                if (took)
                    model();
            end
            @(posedge sys_clk);
            nrst <= 1'b0;
            instr_valid <= 1'b0;
            e_pc = PC_RST;
            e_fl = FLAGS_RST;
            e_cyc = CYC_ONE;
            busy = 0;
            took = 1'b0;
        end
        give_verdict();
    end
endmodule : csbu_unit_tb_top
`default_nettype wire
